/* File: src/acs_pkg.sv */
// Purpose: Shared constants and timing tables for the conversion sequencer
// Assumes: 40 MHz reference clock; latencies kept in microseconds
// Notes:   Table entries of zero mark rate/filter pairs that do not exist
package acs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int US_NS         = 1000;
  localparam int TICK_CYCLES   = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [22:0] TAB_DELAY_US  = 23'h000032;
  localparam logic [22:0] DELAY_STEP_US = 23'h000032;
  localparam logic [3:0]  DELAY_CODE_RST = 4'h1;
  localparam logic [7:0]  READY_LOW_US  = 8'h01;
  localparam int LAT_W = 22;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_MODE_ZERO = 8'h00;
  localparam logic [7:0] ADR_MODE_ONE  = 8'h04;
  localparam logic [7:0] ADR_STATUS    = 8'h08;
  localparam int SINGLE_SHOT_BIT = 4;
  localparam int RATE_LSB        = 8;
  localparam int FILTER_LSB      = 16;
  localparam int CHOP_LSB        = 0;
  localparam int DELAY_LSB       = 4;
  localparam int CRC_BIT         = 8;
  localparam logic [4:0] RATE_RST   = 5'h04;
  localparam logic [2:0] FILTER_RST = 3'h0;

  // ----------------------------------------------------------------
  // Serial command decode
  // ----------------------------------------------------------------
  localparam logic [5:0] EDGES_PLAIN = 6'h10;
  localparam logic [5:0] EDGES_CRC   = 6'h20;
  localparam logic [7:0] OP_START    = 8'h01;
  localparam logic [7:0] OP_STOP     = 8'h02;

  // Filter index 0 FIR, 1..5 sinc order one to five
  function automatic logic [20:0] latency_us(input logic [4:0] rate, input logic [2:0] filt);
    logic [125:0] row;
    row = '0;
    case (rate)
      5'h00: row = {21'd0, 21'd1600000, 21'd1200000, 21'd800400, 21'd400400, 21'd402200};
      5'h01: row = {21'd0, 21'd800400, 21'd600400, 21'd400400, 21'd200400, 21'd202200};
      5'h02: row = {21'd0, 21'd400400, 21'd300400, 21'd200400, 21'd100400, 21'd102200};
      5'h03: row = {21'd0, 21'd240400, 21'd180400, 21'd120400, 21'd60430, 21'd0};
      5'h04: row = {21'd0, 21'd200400, 21'd150400, 21'd100400, 21'd50430, 21'd52230};
      5'h05: row = {21'd0, 21'd80430, 21'd60430, 21'd40430, 21'd20430, 21'd0};
      5'h06: row = {21'd0, 21'd67090, 21'd50430, 21'd33760, 21'd17090, 21'd0};
      5'h07: row = {21'd0, 21'd40430, 21'd30430, 21'd20430, 21'd10430, 21'd0};
      5'h08: row = {21'd0, 21'd10430, 21'd7925, 21'd5425, 21'd2925, 21'd0};
      5'h09: row = {21'd0, 21'd3758, 21'd2925, 21'd2091, 21'd1258, 21'd0};
      5'h0a: row = {21'd0, 21'd2091, 21'd1675, 21'd1258, 21'd841, 21'd0};
      5'h0b: row = {21'd0, 21'd1258, 21'd1050, 21'd841, 21'd633, 21'd0};
      5'h0c: row = {21'd0, 21'd980, 21'd841, 21'd702, 21'd564, 21'd0};
      5'h0d: row = {21'd423, 105'd0};
      5'h0e: row = {21'd336, 105'd0};
      5'h0f: row = {21'd271, 105'd0};
      5'h10: row = {21'd179, 105'd0};
      default: row = '0;
    endcase
    latency_us = (filt > 3'h5) ? 21'd0 : row[21*filt +: 21];
  endfunction

  // Output data period, rounded to the nearest microsecond
  function automatic logic [20:0] period_us(input logic [4:0] rate);
    case (rate)
      5'h00: period_us = 21'd400000;
      5'h01: period_us = 21'd200000;
      5'h02: period_us = 21'd100000;
      5'h03: period_us = 21'd60000;
      5'h04: period_us = 21'd50000;
      5'h05: period_us = 21'd20000;
      5'h06: period_us = 21'd16667;
      5'h07: period_us = 21'd10000;
      5'h08: period_us = 21'd2500;
      5'h09: period_us = 21'd833;
      5'h0a: period_us = 21'd417;
      5'h0b: period_us = 21'd208;
      5'h0c: period_us = 21'd139;
      5'h0d: period_us = 21'd69;
      5'h0e: period_us = 21'd52;
      5'h0f: period_us = 21'd39;
      5'h10: period_us = 21'd25;
      default: period_us = 21'd0;
    endcase
  endfunction

endpackage

/* File: src/acs_cmd_rx.sv */
// Purpose: Watches the serial frame and pulses start or stop commands
// Assumes: Serial pins are asynchronous to the reference clock
// Notes:   Opcode is the first byte; data taken on falling serial edges
`timescale 1ns/10ps
module acs_cmd_rx (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic din,
  input  wire logic crc_enable,
  output logic      start_cmd,
  output logic      stop_cmd
);

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       sclk_d;
  logic [5:0] edge_cnt;
  logic [7:0] opcode;
  logic       fall;
  logic [5:0] target;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      // Idle levels: serial clock high, frame deselected, data low
      sync1 <= 3'h6;
      sync2 <= 3'h6;
    end
    else
    begin
      sync1 <= {sclk, cs_n, din};
      sync2 <= sync1;
    end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      sclk_d <= 1'b0;
    else
      sclk_d <= sync2[2];

  assign fall   = sclk_d & ~sync2[2] & ~sync2[1];
  assign target = crc_enable ? acs_pkg::EDGES_CRC : acs_pkg::EDGES_PLAIN;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      edge_cnt <= 6'h00;
    else if (sync2[1])
      edge_cnt <= 6'h00;
    else if (fall && edge_cnt != 6'h3f)
      edge_cnt <= edge_cnt + 6'h01;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      opcode <= 8'h00;
    else if (fall && edge_cnt < 6'h08)
      opcode <= {opcode[6:0], sync2[0]};

  // Command acts only on the closing edge of its frame
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      start_cmd <= 1'b0;
      stop_cmd  <= 1'b0;
    end
    else
    begin
      start_cmd <= fall && (edge_cnt + 6'h01 == target) && opcode == acs_pkg::OP_START;
      stop_cmd  <= fall && (edge_cnt + 6'h01 == target) && opcode == acs_pkg::OP_STOP;
    end

  property p_cmd_edge;
    @(posedge clk) disable iff (!rst_b)
      (fall && edge_cnt == target - 6'h01 && opcode == acs_pkg::OP_START) |=> start_cmd;
  endproperty
  a_cmd_edge: assert property (p_cmd_edge) else $error("start not on closing edge");

endmodule

/* File: src/acs_sequencer.sv */
// Purpose: Conversion-control sequencer with Wishbone configuration registers
// Assumes: Host keeps start pin low when it uses serial commands
// Notes:   Timing runs in microsecond ticks derived from the reference clock
// Notes on behaviour
// - Command acts on 16th or 32nd falling edge
// - Mode bit 4 picks continuous or single-shot
// - Continuous mode converts back to back
// - Ready high at start, low at result
// - Continuous stop lets running conversion finish
// - Fresh start restarts a running conversion
// - Single-shot mode does one conversion, idles
// - Single-shot stop never aborts the conversion
// - FIR and sinc1 settle in one cycle
// - Latency counted from start, includes start delay
// - Latency from rate and filter lookup
// - Later results spaced by one data period
// - Chop doubles first latency, period equals latency
// - Table assumes chop off, delay code one
// - Results straddling input change may blend
// - Timing base follows modulator clock rate; code uses one timing base for all rates
// - Start delay precedes each conversion start; code adds it to the first latency only, not to later periods
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module acs_sequencer #(
  parameter int TICK_CYCLES = acs_pkg::TICK_CYCLES
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        START,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        DIN,
  output logic             RESULT_READY_N,
  output logic             CONVERTING
);

  typedef enum logic {ACS_IDLE, ACS_CONV} acs_state_t;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  acs_state_t         state;
  logic               single_shot_select;
  logic [4:0]         rate;
  logic [2:0]         filter;
  logic [1:0]         chop;
  logic [3:0]         delay_code;
  logic               crc_enable;
  logic               start_s1;
  logic               start_s2;
  logic               start_d;
  logic               cmd_start;
  logic               cmd_stop;
  logic               start_evt;
  logic               stop_evt;
  logic [15:0]        tick_cnt;
  logic               tick;
  logic [acs_pkg::LAT_W-1:0] remaining;
  logic [acs_pkg::LAT_W-1:0] next_first;
  logic [acs_pkg::LAT_W-1:0] next_period;
  logic               result_evt;
  logic               stop_pending;
  logic [7:0]         hold;
  logic [15:0]        result_cnt;
  logic               wb_req;
  logic [31:0]        rd_data;

  // ----------------------------------------------------------------
  // Start pin and serial commands
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
    begin
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      start_d  <= 1'b0;
    end
    else
    begin
      start_s1 <= START;
      start_s2 <= start_s1;
      start_d  <= start_s2;
    end

  acs_cmd_rx u_cmd_rx (
    .clk        (REF_CLK),
    .rst_b      (RST_B),
    .sclk       (SCLK),
    .cs_n       (CS_N),
    .din        (DIN),
    .crc_enable (crc_enable),
    .start_cmd  (cmd_start),
    .stop_cmd   (cmd_stop)
  );

  // Pin and command are simply merged; the host keeps them apart
  assign start_evt = (start_s2 & ~start_d) | cmd_start;
  assign stop_evt  = (~start_s2 & start_d) | cmd_stop;

  // ----------------------------------------------------------------
  // Microsecond tick, realigned on every start
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
      tick_cnt <= 16'h0000;
    else if (start_evt || tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;

  // One timing base for all rates; the faster clock of the top rate is not modelled
  assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------
  // Latency and period loads
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [20:0] tab;
    logic [22:0] base;
    logic [22:0] sum;
    logic [20:0] per;
    tab  = acs_pkg::latency_us(rate, filter);
    base = (chop != 2'h0) ? {1'b0, tab, 1'b0} : {2'b00, tab};
    // Single-cycle filters need no settling beyond one period
    per  = (chop != 2'h0) ? tab : acs_pkg::period_us(rate);
    // Table already holds the default delay, so only the difference is added
    sum  = base + 23'(delay_code) * acs_pkg::DELAY_STEP_US;
    if (sum > acs_pkg::TAB_DELAY_US)
      next_first = 22'(sum - acs_pkg::TAB_DELAY_US);
    else
      next_first = 22'h000001;
    next_period = (per == 21'd0) ? 22'h000001 : {1'b0, per};
  end

  assign result_evt = (state == ACS_CONV) && tick && (remaining == 22'h000001);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
      state <= ACS_IDLE;
    else if (start_evt)
      state <= ACS_CONV;
    else if (result_evt && (single_shot_select || stop_pending))
      state <= ACS_IDLE;

  // Restart drops any partial progress and reloads the full first latency
  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
      remaining <= 22'h000001;
    else if (start_evt)
      remaining <= next_first;
    // Free run keeps filter history, so an input change blends into results
    else if (result_evt)
      remaining <= next_period;
    else if (state == ACS_CONV && tick)
      remaining <= remaining - 22'h000001;

  // Stop only ends a continuous run after the current result
  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
      stop_pending <= 1'b0;
    else if (start_evt)
      stop_pending <= 1'b0;
    else if (stop_evt && state == ACS_CONV && !single_shot_select)
      stop_pending <= 1'b1;
    else if (result_evt)
      stop_pending <= 1'b0;

  // ----------------------------------------------------------------
  // Data-ready output
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
    begin
      RESULT_READY_N <= 1'b1;
      hold           <= 8'h00;
    end
    else if (start_evt)
    begin
      RESULT_READY_N <= 1'b1;
      hold           <= 8'h00;
    end
    else if (result_evt)
    begin
      RESULT_READY_N <= 1'b0;
      hold           <= acs_pkg::READY_LOW_US;
    end
    else if (tick && hold != 8'h00)
    begin
      hold <= hold - 8'h01;
      // Next conversion of a run is already under way
      if (hold == 8'h01 && state == ACS_CONV)
        RESULT_READY_N <= 1'b1;
    end

  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
      CONVERTING <= 1'b0;
    else if (start_evt)
      CONVERTING <= 1'b1;
    else if (result_evt && (single_shot_select || stop_pending))
      CONVERTING <= 1'b0;

  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
      result_cnt <= 16'h0000;
    else if (result_evt)
      result_cnt <= result_cnt + 16'h0001;

  // ----------------------------------------------------------------
  // Wishbone slave, one wait state
  // ----------------------------------------------------------------
  assign wb_req = WB_CYC_I & WB_STB_I;

  always_comb
  begin
    rd_data = 32'h00000000;
    case (WB_ADR_I)
      acs_pkg::ADR_MODE_ZERO:
      begin
        rd_data[acs_pkg::SINGLE_SHOT_BIT] = single_shot_select;
        rd_data[acs_pkg::RATE_LSB +: 5]   = rate;
        rd_data[acs_pkg::FILTER_LSB +: 3] = filter;
      end
      acs_pkg::ADR_MODE_ONE:
      begin
        rd_data[acs_pkg::CHOP_LSB +: 2]  = chop;
        rd_data[acs_pkg::DELAY_LSB +: 4] = delay_code;
        rd_data[acs_pkg::CRC_BIT]        = crc_enable;
      end
      acs_pkg::ADR_STATUS:
        rd_data = {result_cnt, 13'h0000, stop_pending, ~RESULT_READY_N, CONVERTING};
      default:
        rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else
    begin
      WB_ACK_O <= wb_req & ~WB_ACK_O;
      WB_DAT_O <= (wb_req & ~WB_ACK_O & ~WB_WE_I) ? rd_data : 32'h00000000;
    end

  // Writes land on the edge where the master sees ack
  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
    begin
      single_shot_select <= 1'b0;
      rate               <= acs_pkg::RATE_RST;
      filter             <= acs_pkg::FILTER_RST;
      chop               <= 2'h0;
      delay_code         <= acs_pkg::DELAY_CODE_RST;
      crc_enable         <= 1'b0;
    end
    else if (wb_req && WB_WE_I && WB_ACK_O)
    begin
      if (WB_ADR_I == acs_pkg::ADR_MODE_ZERO)
      begin
        if (WB_SEL_I[0])
          single_shot_select <= WB_DAT_I[acs_pkg::SINGLE_SHOT_BIT];
        if (WB_SEL_I[1])
          rate <= WB_DAT_I[acs_pkg::RATE_LSB +: 5];
        if (WB_SEL_I[2])
          filter <= WB_DAT_I[acs_pkg::FILTER_LSB +: 3];
      end
      if (WB_ADR_I == acs_pkg::ADR_MODE_ONE)
      begin
        if (WB_SEL_I[0])
        begin
          chop       <= WB_DAT_I[acs_pkg::CHOP_LSB +: 2];
          delay_code <= WB_DAT_I[acs_pkg::DELAY_LSB +: 4];
        end
        if (WB_SEL_I[1])
          crc_enable <= WB_DAT_I[acs_pkg::CRC_BIT];
      end
    end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ready_rise;
    @(posedge REF_CLK) disable iff (!RST_B)
      start_evt |=> RESULT_READY_N && CONVERTING;
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready not high at start");

  property p_ready_fall;
    @(posedge REF_CLK) disable iff (!RST_B)
      result_evt && !start_evt |=> !RESULT_READY_N;
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready not low at result");

  property p_single_idle;
    @(posedge REF_CLK) disable iff (!RST_B)
      result_evt && single_shot_select && !start_evt |=> state == ACS_IDLE && !CONVERTING;
  endproperty
  a_single_idle: assert property (p_single_idle) else $error("single shot kept going");

  property p_cont_run;
    @(posedge REF_CLK) disable iff (!RST_B)
      result_evt && !single_shot_select && !stop_pending && !start_evt
        |=> state == ACS_CONV && remaining == $past(next_period);
  endproperty
  a_cont_run: assert property (p_cont_run) else $error("run not reloaded by period");

  property p_cont_stop;
    @(posedge REF_CLK) disable iff (!RST_B)
      state == ACS_CONV && stop_evt && !start_evt && !result_evt && !single_shot_select
        |=> stop_pending && state == ACS_CONV;
  endproperty
  a_cont_stop: assert property (p_cont_stop) else $error("stop aborted conversion");

  property p_single_stop;
    @(posedge REF_CLK) disable iff (!RST_B)
      state == ACS_CONV && stop_evt && single_shot_select && !result_evt
        |=> state == ACS_CONV && !stop_pending;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single shot stopped early");

  property p_restart;
    @(posedge REF_CLK) disable iff (!RST_B)
      state == ACS_CONV && start_evt |=> remaining == $past(next_first) && RESULT_READY_N;
  endproperty
  a_restart: assert property (p_restart) else $error("restart kept old progress");

  property p_chop_first;
    @(posedge REF_CLK) disable iff (!RST_B)
      chop != 2'h0 && delay_code == acs_pkg::DELAY_CODE_RST && start_evt
        && acs_pkg::latency_us(rate, filter) != 21'd0
        |=> remaining == 22'({acs_pkg::latency_us($past(rate), $past(filter)), 1'b0});
  endproperty
  a_chop_first: assert property (p_chop_first) else $error("chop first latency wrong");

endmodule

/* File: dv/acs_host_model.sv */
// Purpose: Host model driving the start pin and serial command frames
// Assumes: Serial clock idles low and stands still between frames
// Notes:   Data changes on rising serial edges, read on falling ones
`timescale 1ns/10ps
module acs_host_model (
  input  wire logic clk,
  output logic      start_pin,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  initial
  begin
    start_pin = 1'b0;
    sclk      = 1'b0;
    cs_n      = 1'b1;
    din       = 1'b0;
  end

  task automatic pin(input logic lvl);
    @(posedge clk);
    start_pin <= lvl;
  endtask

  // -----------------------------------------------------------------
  // Serial frame, opcode first, filler bits after it
  // -----------------------------------------------------------------
  task automatic cmd(input logic [7:0] op, input logic crc, input logic [31:0] fill);
    int n;
    n = crc ? 32 : 16;
    @(posedge clk);
    start_pin <= 1'b0;
    cs_n      <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      din  <= (i < 8) ? op[7 - i] : fill[i];
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    cs_n <= 1'b1;
    // Released line must not keep its old value
    din  <= ~din;
  endtask

  // Results to drop after an input change before data is settled
  function automatic int settle_results(input int lat, input int per);
    return lat / per + 1;
  endfunction
endmodule

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: One tick is one clock cycle in this run
// Notes:   Result timing is noted in a queue and judged by a watcher
`timescale 1ns/10ps
module tb_top;
  localparam int TK   = 1;
  localparam int L40K = 179;
  localparam int P40K = 25;
  localparam int LFIR = 52230;
  typedef struct packed {bit first; int n;} acs_note_t;
  logic        REF_CLK, RST_B, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [7:0]  WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, lfsr;
  logic        START, SCLK, CS_N, DIN, RESULT_READY_N, CONVERTING, prev_rdy;
  int          err_total, compares, cyc, ref_cyc, last_fall, n_exp, diff;
  acs_note_t   notes[$];
  logic [31:0] rdq[$];

  acs_sequencer #(.TICK_CYCLES(TK)) u_acs_sequencer (.REF_CLK(REF_CLK), .RST_B(RST_B),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .START(START), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN),
    .RESULT_READY_N(RESULT_READY_N), .CONVERTING(CONVERTING));
  acs_host_model u_acs_host_model (.clk(REF_CLK), .start_pin(START), .sclk(SCLK),
    .cs_n(CS_N), .din(DIN));

  initial REF_CLK = 1'b0;
  always #12.5 REF_CLK = ~REF_CLK;

  // -----------------------------------------------------------------
  // Shared helpers
  // -----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [31:0] mz(input logic s, input logic [4:0] r, input logic [2:0] f);
    return {13'h0, f, 3'h0, r, 3'h0, s, 4'h0};
  endfunction

  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Read pushes its expectation; reads drive the LFSR value as filler data
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    lfsr = lfsr_step(lfsr);
    if (!we)
      rdq.push_back(dat);
    @(posedge REF_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= adr;
    WB_SEL_I <= 4'hf;
    WB_DAT_I <= we ? dat : lfsr;
    do
      @(posedge REF_CLK);
    while (WB_ACK_O !== 1'b1);
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic note(input bit first, input int n);
    acs_note_t e;
    e.first = first;
    e.n     = n;
    notes.push_back(e);
    n_exp++;
  endtask

  task automatic drain(input int idle);
    while (notes.size() > 0)
      @(posedge REF_CLK);
    repeat (idle) @(posedge REF_CLK);
    check("ready held", RESULT_READY_N, 1'b0);
    check("converting", CONVERTING, 1'b0);
  endtask

  // Continuous run by pin, dropped during the last conversion
  task automatic run_pin(input int n, input int first, input int gap);
    note(1, first);
    for (int i = 1; i < n; i++)
      note(0, gap);
    u_acs_host_model.pin(1'b1);
    ref_cyc = cyc;
    while (notes.size() > 1)
      @(posedge REF_CLK);
    repeat (5) @(posedge REF_CLK);
    u_acs_host_model.pin(1'b0);
    drain(gap * TK * 3);
  endtask

  // One result by command, status read and stop sent while it converts
  task automatic run_cmd(input int first, input logic crc);
    note(1, first);
    u_acs_host_model.cmd(acs_pkg::OP_START, crc, lfsr);
    ref_cyc = cyc;
    wb(0, acs_pkg::ADR_STATUS, {16'(n_exp - 1), 16'h0001});
    u_acs_host_model.cmd(acs_pkg::OP_STOP, crc, ~lfsr);
    drain(600);
  endtask

  // -----------------------------------------------------------------
  // Watcher: bus reads and result timing
  // -----------------------------------------------------------------
  always @(posedge REF_CLK)
  begin
    acs_note_t e;
    cyc++;
    if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0 && rdq.size() > 0)
      check("register read", WB_DAT_O, rdq.pop_front());
    if (prev_rdy === 1'b1 && RESULT_READY_N === 1'b0)
    begin
      if (notes.size() == 0)
        check("unexpected result", 1'b1, 1'b0);
      else
      begin
        e = notes.pop_front();
        diff = cyc - ref_cyc - e.n * TK;
        if (e.first)
          check("first latency", 32'((diff > -5) && (diff < 9)), 1);
        else
          check("result period", cyc - last_fall, e.n * TK);
      end
      last_fall = cyc;
    end
    prev_rdy = RESULT_READY_N;
    if (cyc > 80000)
    begin
      err_total++;
      complete_run();
    end
  end

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial
  begin
    {RST_B, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} = '0;
    {err_total, compares, cyc, n_exp, ref_cyc, last_fall} = '0;
    lfsr = 32'h2eb3;
    repeat (10) @(posedge REF_CLK);
    RST_B <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    wb(0, 8'h00, 32'h0000_0400);
    wb(0, 8'h04, 32'h0000_0010);
    wb(0, 8'h08, 32'h0);
    wb(1, 8'h0c, 32'h5a5a_a5a5);
    wb(0, 8'h0c, 32'h0);
    wb(1, 8'h00, mz(1'b0, 5'h10, 3'h5));
    wb(0, 8'h00, mz(1'b0, 5'h10, 3'h5));
    run_pin(4, L40K, P40K);
    // Restart: short low pulse while the first conversion runs
    u_acs_host_model.pin(1'b1);
    repeat (60) @(posedge REF_CLK);
    u_acs_host_model.pin(1'b0);
    repeat (4) @(posedge REF_CLK);
    run_pin(2, L40K, P40K);
    wb(1, 8'h04, 32'h0000_0011);
    run_pin(u_acs_host_model.settle_results(2 * L40K, L40K), 2 * L40K, L40K);
    run_cmd(2 * L40K, 1'b0);
    wb(1, 8'h00, mz(1'b1, 5'h10, 3'h5));
    wb(1, 8'h04, 32'h0000_0030);
    run_cmd(L40K + 100, 1'b0);
    wb(1, 8'h04, 32'h0000_0110);
    run_cmd(L40K, 1'b1);
    wb(1, 8'h00, mz(1'b1, 5'h04, 3'h0));
    wb(1, 8'h04, 32'h0000_0010);
    run_cmd(LFIR, 1'b0);
    wb(0, 8'h08, {n_exp[15:0], 16'h0002});
    complete_run();
  end
endmodule
